// File: hdl/overlay_ctrl_cfg.svh
`ifndef OVERLAY_CTRL_CFG_SVH
`define OVERLAY_CTRL_CFG_SVH

// register byte addresses on the derivative bus
`define OVL_ADDR_GLOBAL      8'h40
`define OVL_ADDR_ROW0_SIZE   8'h41
`define OVL_ADDR_ROW0_HORIZ  8'h42

// reset value of every control register
`define OVL_REG_RESET        8'h00
`define OVL_READ_IDLE        8'h00

// global control fields
`define OVL_COLOUR_MSB       7
`define OVL_COLOUR_LSB       5
`define OVL_RASTER_BLANK_BIT 4
`define OVL_ROUND_BIT        3
`define OVL_STANDBY_BIT      2
`define OVL_VSYNC_POL_BIT    1
`define OVL_HSYNC_POL_BIT    0

// row 0 size / vertical fields
`define OVL_SIZE_MSB         7
`define OVL_SIZE_LSB         6
`define OVL_VPOS_MSB         5
`define OVL_VPOS_LSB         0

// row 0 horizontal / background / blanking fields
`define OVL_DISP_EN_BIT      7
`define OVL_BG_EN_BIT        6
`define OVL_HPOS_MSB         5
`define OVL_HPOS_LSB         0

// dot timing and row geometry
`define OVL_DOT_DIV          4'h4
`define OVL_POS_SHIFT        2
`define OVL_CHAR_W           3'h5
`define OVL_CHAR_H           4'h8
`define OVL_ROW_CHARS        4'hf

`endif

// File: hdl/overlay_ctrl_pkg.sv
package overlay_ctrl_pkg;

	typedef enum logic [1:0] {
		OSC_STOPPED = 2'b01,
		OSC_RUNNING = 2'b10
	} dot_osc_state_t;

	typedef logic [7:0] ctrl_byte_t;

endpackage

// File: hdl/sync_edge_detect.sv
`timescale 1ns/1ns
module sync_edge_detect (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic pin_i,
	input  wire logic active_high_i,
	output logic      active_o,
	output logic      leading_o,
	output logic      trailing_o
);

	logic stage1;
	logic stage2;
	logic active_q;
	wire  active_now;

	// polarity applied after the second stage only
	assign active_now = active_high_i ? stage2 : ~stage2;
	assign active_o   = active_q;
	assign leading_o  = active_now & ~active_q;
	assign trailing_o = ~active_now & active_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// pins idle high under the reset polarity: no false edge on release
			stage1   <= 1'b1;
			stage2   <= 1'b1;
			active_q <= 1'b0;
		end else begin
			stage1   <= pin_i;
			stage2   <= stage1;
			active_q <= active_now;
		end
	end

endmodule

// File: hdl/half_dot_round.sv
`timescale 1ns/1ns
module half_dot_round (
	input  wire logic       enable_i,
	input  wire logic [8:0] neighbourhood_i,
	output logic            half_dot_o
);

	// neighbourhood: [8:6] line above, [5:3] this line, [2:0] line below; bit order left, centre, right
	wire up_left    = neighbourhood_i[8];
	wire up         = neighbourhood_i[7];
	wire up_right   = neighbourhood_i[6];
	wire left       = neighbourhood_i[5];
	wire centre     = neighbourhood_i[4];
	wire right      = neighbourhood_i[3];
	wire down_left  = neighbourhood_i[2];
	wire down       = neighbourhood_i[1];
	wire down_right = neighbourhood_i[0];

	// an empty dot gets a half dot where two diagonal dots touch at its corner
	wire corner_ul = up & left & ~up_left;
	wire corner_ur = up & right & ~up_right;
	wire corner_dl = down & left & ~down_left;
	wire corner_dr = down & right & ~down_right;

	assign half_dot_o = enable_i & ~centre & (corner_ul | corner_ur | corner_dl | corner_dr);

endmodule

// File: hdl/screen_overlay_ctrl_regs.sv
// Behaviour
// - three eight-bit registers at 40H, 41H, 42H
// - global bits 7..5 carry colour selection
// - raster blank bit forces blanking output high
// - blank release waits for vertical sync trailing
// - rounding bit enables diagonal corner half dots
// - stand-by bit stops the dot oscillator
// - bit 1 sets vertical sync polarity
// - bit 0 sets horizontal sync polarity
// - size bits pick row size, box included
// - six bits set row vertical start
// - display enable gates colour outputs and character/box blanking, not the raster blank hold
// - background enable draws box behind characters
// - horizontal position counts only on dot cycles
// - registers read/write, cleared on reset
`timescale 1ns/1ns
`include "overlay_ctrl_cfg.svh"
module screen_overlay_ctrl_regs (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wr_data_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rd_data_o,
	input  wire logic       vertical_sync_in_i,
	input  wire logic       horizontal_sync_in_i,
	input  wire logic [8:0] char_neighbourhood_i,
	input  wire logic [2:0] char_colour_i,
	output logic [2:0]      colour_sel_o,
	output logic [1:0]      row0_char_size_o,
	output logic            overlay_dot_clock_o,
	output logic            osc_running_o,
	output logic            row0_window_o,
	output logic [3:0]      char_col_o,
	output logic [2:0]      dot_x_o,
	output logic [3:0]      dot_y_o,
	output logic            colour_video_out_a_o,
	output logic            colour_video_out_b_o,
	output logic            colour_video_out_c_o,
	output logic            blanking_video_out_o
);

	////////////////////////////////////////////////////////////////////////////////
	// register file

	overlay_ctrl_pkg::ctrl_byte_t overlay_global_control;
	overlay_ctrl_pkg::ctrl_byte_t row0_size_vertical;
	overlay_ctrl_pkg::ctrl_byte_t row0_horizontal_blank_bg;
	overlay_ctrl_pkg::ctrl_byte_t next_rd_data;

	wire sel_global = (addr_i == `OVL_ADDR_GLOBAL);
	wire sel_size   = (addr_i == `OVL_ADDR_ROW0_SIZE);
	wire sel_horiz  = (addr_i == `OVL_ADDR_ROW0_HORIZ);

	// unmapped addresses read as zero and ignore writes
	assign next_rd_data = !rd_i      ? `OVL_READ_IDLE :
	                      sel_global ? overlay_global_control :
	                      sel_size   ? row0_size_vertical :
	                      sel_horiz  ? row0_horizontal_blank_bg :
	                                   `OVL_READ_IDLE;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			overlay_global_control   <= `OVL_REG_RESET;
			row0_size_vertical       <= `OVL_REG_RESET;
			row0_horizontal_blank_bg <= `OVL_REG_RESET;
		end else if (wr_i) begin
			if (sel_global) begin
				overlay_global_control <= wr_data_i;
			end
			if (sel_size) begin
				row0_size_vertical <= wr_data_i;
			end
			if (sel_horiz) begin
				row0_horizontal_blank_bg <= wr_data_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= `OVL_READ_IDLE;
		end else begin
			rd_data_o <= next_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// field decode

	wire [2:0] colour_sel   = overlay_global_control[`OVL_COLOUR_MSB:`OVL_COLOUR_LSB];
	wire       raster_blank = overlay_global_control[`OVL_RASTER_BLANK_BIT];
	wire       round_en     = overlay_global_control[`OVL_ROUND_BIT];
	wire       standby      = overlay_global_control[`OVL_STANDBY_BIT];
	wire       vsync_pol    = overlay_global_control[`OVL_VSYNC_POL_BIT];
	wire       hsync_pol    = overlay_global_control[`OVL_HSYNC_POL_BIT];
	wire [1:0] char_size    = row0_size_vertical[`OVL_SIZE_MSB:`OVL_SIZE_LSB];
	wire [5:0] vpos         = row0_size_vertical[`OVL_VPOS_MSB:`OVL_VPOS_LSB];
	wire       disp_en      = row0_horizontal_blank_bg[`OVL_DISP_EN_BIT];
	wire       bg_en        = row0_horizontal_blank_bg[`OVL_BG_EN_BIT];
	wire [5:0] hpos         = row0_horizontal_blank_bg[`OVL_HPOS_MSB:`OVL_HPOS_LSB];

	function automatic logic [9:0] start_of(input logic [5:0] pos);
		start_of = {2'b00, pos, 2'b00};
	endfunction

	// each dot is stretched over (size + 1) dot cycles or lines
	wire [1:0] scale_last = char_size;
	wire [9:0] hstart     = start_of(hpos);
	wire [9:0] vstart     = start_of(vpos);

	////////////////////////////////////////////////////////////////////////////////
	// sync inputs

	logic hs_active;
	logic hs_lead;
	logic hs_trail;
	logic vs_active;
	logic vs_lead;
	logic vs_trail;

	sync_edge_detect u_hsync (
		.clk_i         (clk_i),
		.rst_n_i       (rst_n_i),
		.pin_i         (horizontal_sync_in_i),
		.active_high_i (hsync_pol),
		.active_o      (hs_active),
		.leading_o     (hs_lead),
		.trailing_o    (hs_trail)
	);

	sync_edge_detect u_vsync (
		.clk_i         (clk_i),
		.rst_n_i       (rst_n_i),
		.pin_i         (vertical_sync_in_i),
		.active_high_i (vsync_pol),
		.active_o      (vs_active),
		.leading_o     (vs_lead),
		.trailing_o    (vs_trail)
	);

	////////////////////////////////////////////////////////////////////////////////
	// dot oscillator: runs from hsync trailing to next leading edge

	overlay_ctrl_pkg::dot_osc_state_t osc_state;
	overlay_ctrl_pkg::dot_osc_state_t next_osc_state;
	logic [3:0] div_cnt;

	always_comb begin
		next_osc_state = osc_state;
		unique case (osc_state)
			overlay_ctrl_pkg::OSC_STOPPED: begin
				if (hs_trail && !standby) begin
					next_osc_state = overlay_ctrl_pkg::OSC_RUNNING;
				end
			end
			overlay_ctrl_pkg::OSC_RUNNING: begin
				if (hs_lead || standby) begin
					next_osc_state = overlay_ctrl_pkg::OSC_STOPPED;
				end
			end
			default: begin
				next_osc_state = overlay_ctrl_pkg::OSC_STOPPED;
			end
		endcase
	end

	wire running = (osc_state == overlay_ctrl_pkg::OSC_RUNNING);
	wire dot_en  = running && (div_cnt == `OVL_DOT_DIV - 4'h1);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_state <= overlay_ctrl_pkg::OSC_STOPPED;
			div_cnt   <= 4'h0;
		end else begin
			osc_state <= next_osc_state;
			div_cnt   <= (!running || dot_en) ? 4'h0 : div_cnt + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// horizontal position: counted in dot cycles only

	logic [9:0] hcount;
	logic       h_run;
	logic [1:0] h_sub;
	logic [2:0] h_dot;
	logic [3:0] h_col;

	wire h_hit     = (hcount == hstart);
	wire h_sub_end = (h_sub == scale_last);
	wire h_dot_end = (h_dot == `OVL_CHAR_W);
	wire h_col_end = (h_col == `OVL_ROW_CHARS);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hcount <= 10'h000;
			h_run  <= 1'b0;
			h_sub  <= 2'h0;
			h_dot  <= 3'h0;
			h_col  <= 4'h0;
		end else if (hs_lead) begin
			hcount <= 10'h000;
			h_run  <= 1'b0;
		end else if (dot_en) begin
			hcount <= hcount + 10'h001;
			if (h_hit) begin
				h_run <= 1'b1;
				h_sub <= 2'h0;
				h_dot <= 3'h0;
				h_col <= 4'h0;
			end else if (h_run) begin
				h_sub <= h_sub_end ? 2'h0 : h_sub + 2'h1;
				if (h_sub_end) begin
					h_dot <= h_dot_end ? 3'h0 : h_dot + 3'h1;
					if (h_dot_end) begin
						h_col <= h_col + 4'h1;
						h_run <= !h_col_end;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// vertical position: counted in lines, cleared by vsync

	logic [9:0] vcount;
	logic       v_run;
	logic [1:0] v_sub;
	logic [3:0] v_dot;

	wire v_hit     = (vcount == vstart);
	wire v_sub_end = (v_sub == scale_last);
	wire v_dot_end = (v_dot == `OVL_CHAR_H);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vcount <= 10'h000;
			v_run  <= 1'b0;
			v_sub  <= 2'h0;
			v_dot  <= 4'h0;
		end else if (vs_active) begin
			vcount <= 10'h000;
			v_run  <= 1'b0;
		end else if (hs_lead) begin
			vcount <= vcount + 10'h001;
			if (v_hit) begin
				v_run <= 1'b1;
				v_sub <= 2'h0;
				v_dot <= 4'h0;
			end else if (v_run) begin
				v_sub <= v_sub_end ? 2'h0 : v_sub + 2'h1;
				if (v_sub_end) begin
					v_dot <= v_dot_end ? 4'h0 : v_dot + 4'h1;
					v_run <= !v_dot_end;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// raster blanking hold

	logic blank_hold;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			blank_hold <= 1'b0;
		end else if (raster_blank) begin
			blank_hold <= 1'b1;
		end else if (vs_trail) begin
			blank_hold <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pixel composition

	logic half_dot;

	half_dot_round u_round (
		.enable_i        (round_en),
		.neighbourhood_i (char_neighbourhood_i),
		.half_dot_o      (half_dot)
	);

	wire window    = h_run && v_run && running;
	wire ink       = char_neighbourhood_i[4] | half_dot;
	wire box       = bg_en;
	wire show      = disp_en && window;
	wire ink_shown = show && ink;
	wire next_blank = blank_hold || (show && (ink || box));
	wire [2:0] next_colour = ink_shown ? char_colour_i : 3'h0;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			colour_video_out_a_o <= 1'b0;
			colour_video_out_b_o <= 1'b0;
			colour_video_out_c_o <= 1'b0;
			blanking_video_out_o <= 1'b0;
			row0_window_o        <= 1'b0;
			char_col_o           <= 4'h0;
			dot_x_o              <= 3'h0;
			dot_y_o              <= 4'h0;
			colour_sel_o         <= 3'h0;
			row0_char_size_o     <= 2'h0;
			overlay_dot_clock_o  <= 1'b0;
			osc_running_o        <= 1'b0;
		end else begin
			colour_video_out_a_o <= next_colour[0];
			colour_video_out_b_o <= next_colour[1];
			colour_video_out_c_o <= next_colour[2];
			blanking_video_out_o <= next_blank;
			row0_window_o        <= window;
			char_col_o           <= h_col;
			dot_x_o              <= h_dot;
			dot_y_o              <= v_dot;
			colour_sel_o         <= colour_sel;
			row0_char_size_o     <= char_size;
			overlay_dot_clock_o  <= dot_en;
			osc_running_o        <= running;
		end
	end

endmodule

// File: verif/overlay_regs_chk.sv
`timescale 1ns/1ns
module overlay_regs_chk (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rd_data_o,
	input wire logic       vertical_sync_in_i,
	input wire logic       horizontal_sync_in_i,
	input wire logic [8:0] char_neighbourhood_i,
	input wire logic [2:0] char_colour_i,
	input wire logic [2:0] colour_sel_o,
	input wire logic [1:0] row0_char_size_o,
	input wire logic       overlay_dot_clock_o,
	input wire logic       osc_running_o,
	input wire logic       row0_window_o,
	input wire logic [3:0] char_col_o,
	input wire logic [2:0] dot_x_o,
	input wire logic [3:0] dot_y_o,
	input wire logic       colour_video_out_a_o,
	input wire logic       colour_video_out_b_o,
	input wire logic       colour_video_out_c_o,
	input wire logic       blanking_video_out_o
);
	logic       disp_q;
	logic       raster_blank_enable_q;
	logic [2:0] vid;

	assign vid = {colour_video_out_c_o, colour_video_out_b_o, colour_video_out_a_o};

	// shadow copies of the control bits the video path depends on
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			disp_q <= 1'b0;
			raster_blank_enable_q <= 1'b0;
		end else if (wr_i && addr_i == 8'h42) begin
			disp_q <= wr_data_i[7];
		end else if (wr_i && addr_i == 8'h40) begin
			raster_blank_enable_q <= wr_data_i[4];
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_read_idle_zero: assert property (!rd_i |=> rd_data_o == 8'h00)
		else $error("read data not zero outside read cycle");
	a_colour_field_out: assert property (wr_i && addr_i == 8'h40 |-> ##2 colour_sel_o == $past(wr_data_i[7:5], 2))
		else $error("colour select does not follow write");
	a_size_field_out: assert property (wr_i && addr_i == 8'h41 |-> ##2 row0_char_size_o == $past(wr_data_i[7:6], 2))
		else $error("row size does not follow write");
	a_standby_stops_osc: assert property (wr_i && addr_i == 8'h40 && wr_data_i[2] |-> ##[2:4] !osc_running_o)
		else $error("oscillator still running in standby");
	a_dot_pulse_spacing: assert property ($rose(overlay_dot_clock_o) |=> !overlay_dot_clock_o [*3])
		else $error("dot pulses closer than four clocks");
	a_raster_blank_hold: assert property (raster_blank_enable_q [*3] |-> blanking_video_out_o)
		else $error("blanking low while raster blank set");
	a_display_off_dark: assert property (!disp_q [*3] |-> vid == 3'b000)
		else $error("colour output while display disabled");
	a_colour_from_char: assert property (vid != 3'b000 |-> vid == $past(char_colour_i))
		else $error("colour output differs from character colour");
	a_row_start_home: assert property ($rose(row0_window_o) |-> char_col_o == 4'h0 && dot_x_o == 3'h0)
		else $error("row does not start at first dot of first character");
	a_dot_x_in_cell: assert property (dot_x_o <= 3'h5)
		else $error("dot column beyond character cell");
	a_dot_y_in_cell: assert property (dot_y_o <= 4'h8)
		else $error("dot line beyond character cell");

	c_window: cover property (row0_window_o && blanking_video_out_o);
	c_ink: cover property (vid == 3'b101);
	c_osc: cover property ($rose(osc_running_o));
endmodule

bind screen_overlay_ctrl_regs overlay_regs_chk u_chk (
	.clk_i                (clk_i),
	.rst_n_i              (rst_n_i),
	.addr_i               (addr_i),
	.wr_data_i            (wr_data_i),
	.wr_i                 (wr_i),
	.rd_i                 (rd_i),
	.rd_data_o            (rd_data_o),
	.vertical_sync_in_i   (vertical_sync_in_i),
	.horizontal_sync_in_i (horizontal_sync_in_i),
	.char_neighbourhood_i (char_neighbourhood_i),
	.char_colour_i        (char_colour_i),
	.colour_sel_o         (colour_sel_o),
	.row0_char_size_o     (row0_char_size_o),
	.overlay_dot_clock_o  (overlay_dot_clock_o),
	.osc_running_o        (osc_running_o),
	.row0_window_o        (row0_window_o),
	.char_col_o           (char_col_o),
	.dot_x_o              (dot_x_o),
	.dot_y_o              (dot_y_o),
	.colour_video_out_a_o (colour_video_out_a_o),
	.colour_video_out_b_o (colour_video_out_b_o),
	.colour_video_out_c_o (colour_video_out_c_o),
	.blanking_video_out_o (blanking_video_out_o)
);

// File: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic       clk_i     = 1'b0;
	logic       rst_n_i   = 1'b0;
	logic [7:0] addr_i    = 8'h00;
	logic [7:0] wr_data_i = 8'h00;
	logic       wr_i      = 1'b0;
	logic       rd_i      = 1'b0;
	logic       vs_i      = 1'b1;
	logic       hs_i      = 1'b1;
	logic [8:0] nb_i      = 9'h000;
	logic [2:0] cc_i      = 3'h0;
	logic [7:0] rd_data_o;
	logic [2:0] colour_o;
	logic [1:0] size_o;
	logic       dot_o;
	logic       osc_o;
	logic       win_o;
	logic [3:0] col_o;
	logic [2:0] dx_o;
	logic [3:0] dy_o;
	logic       va;
	logic       vb;
	logic       vc;
	logic       blank_o;
	int         err_total = 0;
	int         tests_run = 0;
	int         n;
	int         k;

	always #2 clk_i = ~clk_i;

	screen_overlay_ctrl_regs u_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
		.wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .vertical_sync_in_i(vs_i),
		.horizontal_sync_in_i(hs_i), .char_neighbourhood_i(nb_i), .char_colour_i(cc_i),
		.colour_sel_o(colour_o), .row0_char_size_o(size_o), .overlay_dot_clock_o(dot_o),
		.osc_running_o(osc_o), .row0_window_o(win_o), .char_col_o(col_o), .dot_x_o(dx_o), .dot_y_o(dy_o),
		.colour_video_out_a_o(va), .colour_video_out_b_o(vb), .colour_video_out_c_o(vc),
		.blanking_video_out_o(blank_o)
	);

	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// settle one time unit past the edge before sampling
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i    <= a;
		wr_data_i <= d;
		wr_i      <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rd_data_o, exp);
	endtask

	task automatic await(input int sel);
		for (n = 0; n < 400; n++) begin
			cyc(1);
			if (sel == 0 ? osc_o === 1'b1 : win_o === 1'b1)
				break;
		end
		if (n == 400) begin
			err_total++;
			finish_test();
		end
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		finish_test();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(8'h40, 8'h00);
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h00);
		$display("test reset done");
		wr(8'h40, 8'hab);
		wr(8'h41, 8'hd5);
		wr(8'h42, 8'h6a);
		wr(8'h43, 8'hff);
		rd(8'h40, 8'hab);
		rd(8'h41, 8'hd5);
		rd(8'h42, 8'h6a);
		rd(8'h43, 8'h00);
		rd(8'h3f, 8'h00);
		chk({5'h00, colour_o}, 8'h05);
		for (k = 0; k < 4; k++) begin
			wr(8'h41, {2'(k), 6'h00});
			cyc(2);
			chk({6'h00, size_o}, 8'(k));
		end
		$display("test registers done");
		wr(8'h40, 8'h00);
		wr(8'h42, 8'h00);
		wr(8'h40, 8'h10);
		cyc(3);
		chk({7'h00, blank_o}, 8'h01);
		wr(8'h40, 8'h00);
		cyc(20);
		chk({7'h00, blank_o}, 8'h01);
		@(posedge clk_i);
		vs_i <= 1'b0;
		cyc(10);
		chk({7'h00, blank_o}, 8'h01);
		@(posedge clk_i);
		vs_i <= 1'b1;
		cyc(8);
		chk({7'h00, blank_o}, 8'h00);
		$display("test raster blank done");
		@(posedge clk_i);
		vs_i <= 1'b0;
		hs_i <= 1'b0;
		wr(8'h41, 8'h00);
		wr(8'h42, 8'hc0);
		wr(8'h40, 8'h0b);
		@(posedge clk_i);
		hs_i <= 1'b1;
		cyc(10);
		chk({7'h00, osc_o}, 8'h00);
		@(posedge clk_i);
		hs_i <= 1'b0;
		await(0);
		k = 0;
		repeat (40) begin
			cyc(1);
			k += (dot_o === 1'b1);
		end
		chk(8'(k), 8'h0a);
		await(1);
		cyc(2);
		chk({7'h00, blank_o}, 8'h01);
		chk({4'h0, col_o}, 8'h01);
		chk({5'h00, dx_o}, 8'h03);
		chk({4'h0, dy_o}, 8'h00);
		@(posedge clk_i);
		cc_i <= 3'b101;
		nb_i <= 9'h010;
		cyc(2);
		chk({5'h00, vc, vb, va}, 8'h05);
		@(posedge clk_i);
		nb_i <= 9'h0a0;
		cyc(2);
		chk({5'h00, vc, vb, va}, 8'h05);
		wr(8'h40, 8'h03);
		cyc(2);
		chk({5'h00, vc, vb, va}, 8'h00);
		@(posedge clk_i);
		nb_i <= 9'h010;
		wr(8'h42, 8'h00);
		cyc(2);
		chk({4'h0, blank_o, vc, vb, va}, 8'h00);
		wr(8'h40, 8'h07);
		cyc(4);
		chk({7'h00, osc_o}, 8'h00);
		$display("test video done");
		wr(8'h41, 8'h3f);
		wr(8'h42, 8'h55);
		rd(8'h41, 8'h3f);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		cyc(2);
		chk({2'h0, size_o, 1'b0, osc_o, blank_o, win_o}, 8'h00);
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(8'h40, 8'h00);
		rd(8'h41, 8'h00);
		rd(8'h42, 8'h00);
		$display("test second reset done");
		finish_test();
	end
endmodule
